// ### verilog/sctp_top.sv
`timescale 1ns/1ps
module sctp_top (
  input wire logic core_clk_i, // 20 MHz core clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable, freezes all state when low
  input wire logic iface_select_i, // High selects serial control mode
  input wire logic bclk_i, // Bit clock pin, input side
  output logic bclk_o, // Bit clock pin, output side
  output logic bclk_oe_o, // Bit clock drive enable
  input wire logic tx_frame_sync_i, // Transmit frame sync pin in
  output logic tx_frame_sync_o, // Transmit frame sync pin out
  output logic tx_frame_sync_oe_o, // Transmit frame sync drive enable
  input wire logic rx_frame_sync_i, // Receive frame sync pin in
  output logic rx_frame_sync_o, // Receive frame sync pin out
  output logic rx_frame_sync_oe_o, // Receive frame sync drive enable
  input wire logic tx_serial_data_in_i, // Serial B data from backplane
  output logic rx_serial_data_out_o, // Serial B data to backplane
  output logic rx_serial_data_out_oe_o, // Three-state enable
  input wire logic dchan_data_in_i, // D port data in
  output logic dchan_data_out_o, // D port data out
  output logic dchan_data_out_oe_o, // Three-state enable
  output logic dchan_clock_o, // 16 kHz D clock
  output logic dchan_clock_oe_o, // D clock drive enable
  input wire logic cs_n_i, // Control chip select, active low
  input wire logic ctrl_clock_i, // Control clock
  input wire logic ctrl_data_in_i, // Control data in
  output logic ctrl_data_out_o, // Control data out
  output logic ctrl_data_out_oe_o, // Three-state enable
  output logic irq_n_o, // Open-drain interrupt, always low level
  output logic irq_oe_o, // High while pulling interrupt low
  input wire logic [7:0] line_status_i, // Loop status, core domain
  output logic power_up_o, // Power-up command bit
  output logic [7:0] cmd_one_o, // Command register one
  output logic [7:0] cmd_two_o, // Command register two
  output logic [17:0] tx_word_o, // Captured frame word, B1 B2 D
  output logic tx_word_valid_o, // Frame word waiting
  input wire logic tx_word_ready_i, // Consumer takes frame word
  output logic tx_overrun_o, // Pulse: frame word lost, buffer full
  input wire logic [17:0] rx_word_i, // Frame word to send, B1 B2 D
  input wire logic rx_word_valid_i, // Word offered
  output logic rx_word_ready_o // Pulse: word taken at receive frame start
);
  typedef enum logic [1:0] {
    CP_IDLE = 2'b01,
    CP_SHIFT = 2'b10
  } sctp_cp_type;

  typedef struct packed {
    logic prev_bclk;
    logic prev_txfs;
    logic prev_rxfs;
    logic prev_ctrl_clock;
    logic prev_cs_n;
    logic prev_bgen;
    logic prev_dchan_clock;
    logic [sctp_pkg::NCO_W-1:0] nco_b;
    logic [sctp_pkg::NCO_W-1:0] nco_d;
    logic [sctp_pkg::FCNT_W-1:0] fcnt;
    logic fs_gen;
    logic tx_act;
    logic [4:0] tx_cnt;
    logic [17:0] tx_sh;
    logic rx_act;
    logic [4:0] rx_cnt;
    logic [17:0] rx_sh;
    logic [1:0] d_tx;
    logic [1:0] d_rx;
    logic push;
    logic [17:0] word;
    sctp_cp_type cp_st;
    logic [4:0] cp_cnt;
    logic [15:0] cp_in;
    logic [7:0] cp_out;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] stat_prev;
    logic irq;
  } sctp_state_type;

  sctp_state_type s_reg, s_next;
  logic master;
  logic [8:0] pins;
  logic [8:0] sy;
  logic bclk_s, txfs_s, rxfs_s, bx_s, dx_s, cs_n_s, ctrl_clock_s, ci_s, sel_s;
  logic dport, dchan_clock_mode, dport_bclk, d_on_b;
  logic [4:0] nb;
  logic buf_ready;
  logic b_rise, b_fall, txfs_rise, rxfs_rise, c_rise, c_fall, cs_fall, cs_rise;
  logic tx_bit;

  // Mode decode from the command registers
  assign master = s_reg.cr1[sctp_pkg::CR1_MASTER_BIT];
  assign dport = s_reg.cr2[sctp_pkg::CR2_DPORT_BIT];
  assign dchan_clock_mode = dport && !s_reg.cr2[sctp_pkg::CR2_DCHAN_CLOCK_SEL_BIT];
  assign dport_bclk = dport && s_reg.cr2[sctp_pkg::CR2_DCHAN_CLOCK_SEL_BIT];
  assign d_on_b = !dport && s_reg.cr2[sctp_pkg::CR2_D_ON_B_BIT];
  assign nb = (d_on_b || dport_bclk) ? sctp_pkg::BD_SLOTS : sctp_pkg::B_SLOTS;

  // In master mode our own clock and syncs go through the same path as
  // external ones, so every data edge lines up with its sampled clock
  assign pins = {master ? s_reg.nco_b[sctp_pkg::NCO_W-1] : bclk_i,
                 master ? s_reg.fs_gen : tx_frame_sync_i,
                 master ? s_reg.fs_gen : rx_frame_sync_i,
                 tx_serial_data_in_i, dchan_data_in_i,
                 cs_n_i, ctrl_clock_i, ctrl_data_in_i, iface_select_i};

  // Every foreign input is resynchronised before edge detection; the reset
  // pattern matches the idle pins (chip select high, all others low) so no false edge follows
  sctp_sync #(.W(9), .RST(9'h008)) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(pins),
    .q_o(sy)
  );
  assign {bclk_s, txfs_s, rxfs_s, bx_s, dx_s, cs_n_s, ctrl_clock_s, ci_s, sel_s} = sy;

  // Edge detection on synchronised levels
  assign b_rise = bclk_s && !s_reg.prev_bclk;
  assign b_fall = !bclk_s && s_reg.prev_bclk;
  assign txfs_rise = sel_s && txfs_s && !s_reg.prev_txfs;
  assign rxfs_rise = sel_s && rxfs_s && !s_reg.prev_rxfs;
  assign c_rise = ctrl_clock_s && !s_reg.prev_ctrl_clock;
  assign c_fall = !ctrl_clock_s && s_reg.prev_ctrl_clock;
  assign cs_fall = sel_s && !cs_n_s && s_reg.prev_cs_n;
  assign cs_rise = cs_n_s && !s_reg.prev_cs_n;
  assign tx_bit = (dport_bclk && s_reg.tx_cnt >= sctp_pkg::B_SLOTS) ? dx_s : bx_s;

  always_comb begin
    s_next = s_reg;
    s_next.prev_bclk = bclk_s;
    s_next.prev_txfs = txfs_s;
    s_next.prev_rxfs = rxfs_s;
    s_next.prev_ctrl_clock = ctrl_clock_s;
    s_next.prev_cs_n = cs_n_s;
    s_next.prev_bgen = s_reg.nco_b[sctp_pkg::NCO_W-1];
    s_next.prev_dchan_clock = s_reg.nco_d[sctp_pkg::NCO_W-1];
    s_next.push = 1'b0;

    // Clock generators; the bit clock rate comes from command one
    s_next.nco_b = s_reg.nco_b + sctp_pkg::rate_inc(
                   s_reg.cr1[sctp_pkg::CR1_RATE_LSB +: 3]);
    s_next.nco_d = s_reg.nco_d + sctp_pkg::INC_DCHAN_CLOCK;

    // Master frame sync: one bit clock high at the start of each 8 kHz frame
    if (s_reg.nco_b[sctp_pkg::NCO_W-1] && !s_reg.prev_bgen) begin
      if (s_reg.fcnt + 9'h001 >= sctp_pkg::frame_bits(s_reg.cr1[sctp_pkg::CR1_RATE_LSB +: 3]))
      begin
        s_next.fcnt = '0;
        s_next.fs_gen = 1'b1;
      end else begin
        s_next.fcnt = s_reg.fcnt + 9'h001;
        s_next.fs_gen = 1'b0;
      end
    end

    // Transmit: capture on bit clock falling edges after the frame sync
    if (txfs_rise) begin
      s_next.tx_act = 1'b1;
      s_next.tx_cnt = '0;
    end else if (s_reg.tx_act && b_fall) begin
      s_next.tx_sh = {s_reg.tx_sh[16:0], tx_bit};
      s_next.tx_cnt = s_reg.tx_cnt + 5'h01;
      if (s_reg.tx_cnt + 5'h01 == nb) begin
        s_next.tx_act = 1'b0;
        s_next.push = 1'b1;
        if (nb == sctp_pkg::BD_SLOTS) begin
          s_next.word = {s_reg.tx_sh[16:0], tx_bit};
        end else begin
          s_next.word = {s_reg.tx_sh[14:0], tx_bit,
                         dchan_clock_mode ? s_reg.d_tx : sctp_pkg::D_IDLE};
        end
      end
    end
    if (!sel_s) begin
      s_next.tx_act = 1'b0;
      s_next.rx_act = 1'b0;
    end

    // Receive: first bit driven from the frame sync edge, then shift on rising
    if (rxfs_rise) begin
      s_next.rx_act = 1'b1;
      s_next.rx_cnt = '0;
      s_next.rx_sh = rx_word_valid_i ? rx_word_i : '1;
      s_next.d_rx = rx_word_valid_i ? rx_word_i[1:0] : sctp_pkg::D_IDLE;
    end else if (s_reg.rx_act && b_rise) begin
      s_next.rx_sh = {s_reg.rx_sh[16:0], 1'b1};
      s_next.rx_cnt = s_reg.rx_cnt + 5'h01;
      if (s_reg.rx_cnt + 5'h01 == nb) begin
        s_next.rx_act = 1'b0;
      end
    end

    // Separate D port on its own 16 kHz clock: in on falling, out on rising
    if (s_reg.prev_dchan_clock && !s_reg.nco_d[sctp_pkg::NCO_W-1]) begin
      s_next.d_tx = {s_reg.d_tx[0], dx_s};
    end else if (!s_reg.prev_dchan_clock && s_reg.nco_d[sctp_pkg::NCO_W-1] && !rxfs_rise) begin
      s_next.d_rx = {s_reg.d_rx[0], 1'b1};
    end

    // Control port; power state does not gate it
    unique case (s_reg.cp_st)
      CP_IDLE: begin
        if (cs_fall) begin
          s_next.cp_st = CP_SHIFT;
          s_next.cp_cnt = '0;
          s_next.cp_out = line_status_i;
        end
      end
      CP_SHIFT: begin
        if (cs_rise) begin
          s_next.cp_st = CP_IDLE;
          if (s_reg.cp_cnt == sctp_pkg::CP_WRITE_BITS) begin
            if (s_reg.cp_in[sctp_pkg::CP_ADDR_LSB +: 4] == sctp_pkg::ADDR_CR1) begin
              s_next.cr1 = s_reg.cp_in[7:0];
            end else if (s_reg.cp_in[sctp_pkg::CP_ADDR_LSB +: 4] == sctp_pkg::ADDR_CR2) begin
              s_next.cr2 = s_reg.cp_in[7:0];
            end
          end
        end else if (c_rise) begin
          s_next.cp_in = {s_reg.cp_in[14:0], ci_s};
          if (s_reg.cp_cnt != 5'h1F) begin
            s_next.cp_cnt = s_reg.cp_cnt + 5'h01;
          end
        end else if (c_fall) begin
          s_next.cp_out = {s_reg.cp_out[6:0], 1'b0};
        end
      end
      default: s_next.cp_st = CP_IDLE;
    endcase

    // Interrupt latch; a new change beats a clearing status read
    s_next.stat_prev = line_status_i;
    if (line_status_i != s_reg.stat_prev) begin
      s_next.irq = 1'b1;
    end else if (s_reg.cp_st == CP_SHIFT && cs_rise &&
                 s_reg.cp_cnt >= sctp_pkg::CP_READ_BITS) begin
      s_next.irq = 1'b0;
    end
  end

  // State register; reset leaves both command registers cleared, powered down
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.prev_cs_n <= 1'b1;
      s_reg.cp_st <= CP_IDLE;
      s_reg.cr1 <= sctp_pkg::CR1_RST;
      s_reg.cr2 <= sctp_pkg::CR2_RST;
      s_reg.d_tx <= sctp_pkg::D_IDLE;
      s_reg.d_rx <= sctp_pkg::D_IDLE;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // Frame words wait here so a slow consumer does not lose the next frame
  sctp_buf2 #(.W(sctp_pkg::WORD_W)) u_buf (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(s_reg.push),
    .in_ready_o(buf_ready),
    .in_data_i(s_reg.word),
    .out_valid_o(tx_word_valid_o),
    .out_ready_i(tx_word_ready_i),
    .out_data_o(tx_word_o)
  );
  assign tx_overrun_o = s_reg.push && !buf_ready;

  // Pin drivers; syncs and bit clock are driven only in master mode, the D clock whenever the D port is on and the interface select is high
  assign bclk_o = s_reg.nco_b[sctp_pkg::NCO_W-1];
  assign bclk_oe_o = master && sel_s;
  assign tx_frame_sync_o = s_reg.fs_gen;
  assign tx_frame_sync_oe_o = master && sel_s;
  assign rx_frame_sync_o = s_reg.fs_gen;
  assign rx_frame_sync_oe_o = master && sel_s;
  assign rx_serial_data_out_o = s_reg.rx_sh[17];
  assign rx_serial_data_out_oe_o = s_reg.rx_act &&
                                   (s_reg.rx_cnt < sctp_pkg::B_SLOTS || d_on_b);
  assign dchan_data_out_o = dchan_clock_mode ? s_reg.d_rx[1] : s_reg.rx_sh[17];
  assign dchan_data_out_oe_o = sel_s && (dchan_clock_mode || (dport_bclk && s_reg.rx_act &&
                               s_reg.rx_cnt >= sctp_pkg::B_SLOTS));
  assign dchan_clock_o = s_reg.nco_d[sctp_pkg::NCO_W-1];
  assign dchan_clock_oe_o = dport && sel_s;
  assign ctrl_data_out_o = s_reg.cp_out[7];
  assign ctrl_data_out_oe_o = (s_reg.cp_st == CP_SHIFT) && !cs_n_s;
  assign irq_n_o = 1'b0;
  assign irq_oe_o = s_reg.irq;
  assign power_up_o = s_reg.cr2[sctp_pkg::CR2_PWR_UP_BIT];
  assign cmd_one_o = s_reg.cr1;
  assign cmd_two_o = s_reg.cr2;
  assign rx_word_ready_o = rxfs_rise && rx_word_valid_i;
endmodule

// ### verilog/sctp_pkg.sv
// Notes on behaviour
// - Slave bit clock may be unrelated to the core clock.
// - Master mode drives bit clock at one of five rates from command one.
// - Serial data in and out move in step with the bit clock.
// - Transmit frame sync rising edge starts capture of the first B channel.
// - Receive frame sync rising edge starts driving receive B channel data.
// - Master mode drives both frame syncs to suit the selected format.
// - Receive data pin is three-state, released outside its slots.
// - Control data output is high impedance while chip select is high.
// - Control clock may be unrelated to the bit clock.
// - Open-drain interrupt latches low on any loop status change.
// - Reading the status register clears the interrupt latch.
// - D input sampled on D clock or bit clock, chosen by command two.
// - D output is three-state, clocked like the D input.
// - D port enabled drives a 16 kHz D clock.
// - Control port works whether powered up or down.
// - Reset clears command registers and enters power down.
package sctp_pkg;
  localparam longint CORE_HZ = 20_000_000;
  localparam int NCO_W = 24;
  localparam longint NCO_ONE = 64'sd1 <<< NCO_W;
  localparam longint BCLK_HZ_256K = 256_000;
  localparam longint BCLK_HZ_512K = 512_000;
  localparam longint BCLK_HZ_1536K = 1_536_000;
  localparam longint BCLK_HZ_2048K = 2_048_000;
  localparam longint BCLK_HZ_2560K = 2_560_000;
  localparam longint DCHAN_CLOCK_HZ = 16_000;
  localparam longint FRAME_HZ = 8_000;
  // Phase increments of the clock generators
  localparam logic [NCO_W-1:0] INC_256K = NCO_W'(BCLK_HZ_256K * NCO_ONE / CORE_HZ);
  localparam logic [NCO_W-1:0] INC_512K = NCO_W'(BCLK_HZ_512K * NCO_ONE / CORE_HZ);
  localparam logic [NCO_W-1:0] INC_1536K = NCO_W'(BCLK_HZ_1536K * NCO_ONE / CORE_HZ);
  localparam logic [NCO_W-1:0] INC_2048K = NCO_W'(BCLK_HZ_2048K * NCO_ONE / CORE_HZ);
  localparam logic [NCO_W-1:0] INC_2560K = NCO_W'(BCLK_HZ_2560K * NCO_ONE / CORE_HZ);
  localparam logic [NCO_W-1:0] INC_DCHAN_CLOCK = NCO_W'(DCHAN_CLOCK_HZ * NCO_ONE / CORE_HZ);
  // Bit clock rate codes in command one
  localparam logic [2:0] RATE_256K = 3'h0;
  localparam logic [2:0] RATE_512K = 3'h1;
  localparam logic [2:0] RATE_1536K = 3'h2;
  localparam logic [2:0] RATE_2048K = 3'h3;
  localparam logic [2:0] RATE_2560K = 3'h4;
  localparam int FCNT_W = 9;
  // Command register fields and reset values
  localparam int CR1_RATE_LSB = 0;
  localparam int CR1_MASTER_BIT = 3;
  localparam int CR2_DPORT_BIT = 0;
  localparam int CR2_DCHAN_CLOCK_SEL_BIT = 1;
  localparam int CR2_D_ON_B_BIT = 2;
  localparam int CR2_PWR_UP_BIT = 3;
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] CR2_RST = 8'h00;
  // Control frame layout: address nibble on top, data byte at the bottom
  localparam int CP_ADDR_LSB = 12;
  localparam logic [3:0] ADDR_CR1 = 4'h1;
  localparam logic [3:0] ADDR_CR2 = 4'h2;
  localparam logic [4:0] CP_READ_BITS = 5'h08;
  localparam logic [4:0] CP_WRITE_BITS = 5'h10;
  // Slot counts per frame
  localparam int WORD_W = 18;
  localparam logic [4:0] B_SLOTS = 5'h10;
  localparam logic [4:0] BD_SLOTS = 5'h12;
  localparam logic [1:0] D_IDLE = 2'h3;

  function automatic logic [NCO_W-1:0] rate_inc(input logic [2:0] r);
    case (r)
      RATE_512K: rate_inc = INC_512K;
      RATE_1536K: rate_inc = INC_1536K;
      RATE_2048K: rate_inc = INC_2048K;
      RATE_2560K: rate_inc = INC_2560K;
      default: rate_inc = INC_256K;
    endcase
  endfunction

  function automatic logic [FCNT_W-1:0] frame_bits(input logic [2:0] r);
    case (r)
      RATE_512K: frame_bits = FCNT_W'(BCLK_HZ_512K / FRAME_HZ);
      RATE_1536K: frame_bits = FCNT_W'(BCLK_HZ_1536K / FRAME_HZ);
      RATE_2048K: frame_bits = FCNT_W'(BCLK_HZ_2048K / FRAME_HZ);
      RATE_2560K: frame_bits = FCNT_W'(BCLK_HZ_2560K / FRAME_HZ);
      default: frame_bits = FCNT_W'(BCLK_HZ_256K / FRAME_HZ);
    endcase
  endfunction
endpackage

// ### verilog/sctp_sync.sv
`timescale 1ns/1ps
module sctp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic [W-1:0] d_i, // Foreign-domain levels
  output logic [W-1:0] q_o // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sctp_sync_type;
  sctp_sync_type s_reg, s_next;

  // First stage is read only by the second stage
  always_comb begin
    s_next = s_reg;
    s_next.s1 = d_i;
    s_next.s2 = s_reg.s1;
  end

  // Two stage register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '{s1: RST, s2: RST};
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.s2;
endmodule

// ### verilog/sctp_buf2.sv
`timescale 1ns/1ps
module sctp_buf2 #(
  parameter int W = 18
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic in_valid_i, // Write offer
  output logic in_ready_o, // Space left
  input wire logic [W-1:0] in_data_i, // Write data
  output logic out_valid_o, // Word waiting
  input wire logic out_ready_i, // Reader takes word
  output logic [W-1:0] out_data_o // Oldest word, registered
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
  } sctp_buf_type;
  sctp_buf_type s_reg, s_next;
  logic push;
  logic pop;

  // Slot 0 always holds the oldest word so the output needs no mux
  always_comb begin
    s_next = s_reg;
    push = in_valid_i && (s_reg.cnt != 2'h2);
    pop = out_ready_i && (s_reg.cnt != 2'h0);
    if (pop) begin
      s_next.mem[0] = s_reg.mem[1];
    end
    if (push) begin
      if (s_reg.cnt == 2'h0 || (s_reg.cnt == 2'h1 && pop)) begin
        s_next.mem[0] = in_data_i;
      end else begin
        s_next.mem[1] = in_data_i;
      end
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 2'h1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign in_ready_o = (s_reg.cnt != 2'h2);
  assign out_valid_o = (s_reg.cnt != 2'h0);
  assign out_data_o = s_reg.mem[0];
endmodule

// ### tb/sctp_top_sva.sv
`timescale 1ns/1ps
module sctp_top_sva (
  input wire logic core_clk_i, // Clock
  input wire logic rstn_i, // Reset
  input wire logic cs_n_i, // Select
  input wire logic ctrl_data_out_oe_o, // Status drive
  input wire logic [7:0] line_status_i, // Loop status
  input wire logic irq_n_o, // Irq level
  input wire logic irq_oe_o, // Irq drive
  input wire logic [7:0] cmd_one_o, // Command one
  input wire logic [7:0] cmd_two_o, // Command two
  input wire logic power_up_o, // Power state
  input wire logic bclk_oe_o, // Clock drive
  input wire logic tx_frame_sync_oe_o, // Sync drive
  input wire logic rx_frame_sync_oe_o, // Sync drive
  input wire logic rx_word_valid_i, // Offered
  input wire logic rx_word_ready_o, // Taken
  input wire logic tx_word_valid_o, // Waiting
  input wire logic tx_word_ready_i, // Drained
  input wire logic [17:0] tx_word_o, // Word
  input wire logic tx_overrun_o // Lost
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Pins pass synchronisers, so states are judged after they have settled
  sequence cs_idle;
    cs_n_i [*6];
  endsequence
  sequence master_cfg;
    cmd_one_o[3] [*3];
  endsequence
  sequence slave_cfg;
    !cmd_one_o[3] [*3];
  endsequence
  chk_co_hiz: assert property (cs_idle |-> !ctrl_data_out_oe_o)
    else $error("status output driven while deselected");
  chk_irq_set: assert property ($changed(line_status_i) |-> ##[1:4] irq_oe_o)
    else $error("status change did not raise interrupt");
  chk_irq_latch: assert property ((cs_idle ##0 irq_oe_o) |=> irq_oe_o)
    else $error("interrupt dropped without a read");
  chk_irq_level: assert property (irq_oe_o |-> !irq_n_o)
    else $error("interrupt not pulled low");
  chk_master_drv: assert property (master_cfg |-> bclk_oe_o && tx_frame_sync_oe_o && rx_frame_sync_oe_o)
    else $error("master pins not driven");
  chk_slave_rel: assert property (slave_cfg |-> !bclk_oe_o && !tx_frame_sync_oe_o && !rx_frame_sync_oe_o)
    else $error("slave pins driven");
  chk_rx_take: assert property (rx_word_ready_o |-> rx_word_valid_i ##1 !rx_word_ready_o)
    else $error("word taken wrongly");
  chk_tx_hold: assert property (tx_word_valid_o && !tx_word_ready_i |=> tx_word_valid_o && $stable(tx_word_o))
    else $error("waiting word lost or changed");
  chk_ovr_full: assert property (tx_overrun_o |-> tx_word_valid_o ##1 !tx_overrun_o)
    else $error("overrun without full buffer");
  chk_pwr_bit: assert property (power_up_o == cmd_two_o[3])
    else $error("power state differs from command");
endmodule

bind sctp_top sctp_top_sva chk_i (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .ctrl_data_out_oe_o(ctrl_data_out_oe_o), .line_status_i(line_status_i), .irq_n_o(irq_n_o),
  .irq_oe_o(irq_oe_o), .cmd_one_o(cmd_one_o), .cmd_two_o(cmd_two_o), .power_up_o(power_up_o),
  .bclk_oe_o(bclk_oe_o), .tx_frame_sync_oe_o(tx_frame_sync_oe_o),
  .rx_frame_sync_oe_o(rx_frame_sync_oe_o), .rx_word_valid_i(rx_word_valid_i),
  .rx_word_ready_o(rx_word_ready_o), .tx_word_valid_o(tx_word_valid_o),
  .tx_word_ready_i(tx_word_ready_i), .tx_word_o(tx_word_o), .tx_overrun_o(tx_overrun_o)
);

// ### tb/sctp_far_model.sv
`timescale 1ns/1ps
module sctp_far_model (
  output logic bclk_o, // Bit clock
  output logic tx_fs_o, // Transmit sync
  output logic rx_fs_o, // Receive sync
  output logic bx_o, // Data to device
  input wire logic br_i, // Data from device
  input wire logic br_oe_i // Its drive enable
);
  // Bit clock stands still between frames
  initial begin
    bclk_o = 1'b0;
    tx_fs_o = 1'b0;
    rx_fs_o = 1'b0;
    bx_o = 1'b0;
  end
  // One frame of 20 bits: 16 B slots, then idle bits with toggling data
  // Bit clock period of 400 ns comes from the delays inside this task
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic [1:0] oe);
    #13;
    for (int k = 0; k < 20; k++) begin
      bclk_o = 1'b1;
      tx_fs_o = (k == 0);
      rx_fs_o = (k == 0);
      bx_o = (k < 16) ? tx[15 - k] : ~bx_o;
      #200;
      bclk_o = 1'b0;
      if (k < 16) rx[15 - k] = br_i;
      if (k == 0) oe[1] = br_oe_i;
      if (k == 19) oe[0] = br_oe_i;
      #200;
    end
  endtask
endmodule

// ### tb/sctp_top_tb.sv
`timescale 1ns/1ps
module sctp_top_tb;
  logic core_clk_i, rstn_i, cs_n_i, ctrl_clock_i, ctrl_data_in_i, tx_word_ready_i, prev;
  logic rx_word_valid_i, bclk, tx_fs, rx_fs, bx, bclk_o, bclk_oe_o, rx_serial_data_out_o;
  logic rx_serial_data_out_oe_o, ctrl_data_out_o, ctrl_data_out_oe_o, irq_n_o, irq_oe_o;
  logic power_up_o, tx_word_valid_o, tx_overrun_o, sel;
  logic [7:0] line_status_i, cmd_one_o, cmd_two_o, st;
  logic [17:0] tx_word_o, rx_word_i;
  logic [15:0] rxb;
  logic [1:0] oe;
  logic [31:0] seed;
  int mismatches, checks, ovr, eovr, cyc, n, d;
  int txq[$];
  int khz[5] = '{256, 512, 1536, 2048, 2560};

  sctp_top uut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .iface_select_i(sel),
    .bclk_i(bclk), .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .tx_frame_sync_i(tx_fs),
    .tx_frame_sync_o(), .tx_frame_sync_oe_o(), .rx_frame_sync_i(rx_fs),
    .rx_frame_sync_o(), .rx_frame_sync_oe_o(), .tx_serial_data_in_i(bx),
    .rx_serial_data_out_o(rx_serial_data_out_o), .rx_serial_data_out_oe_o(rx_serial_data_out_oe_o),
    .dchan_data_in_i(1'b0),
    .dchan_data_out_o(), .dchan_data_out_oe_o(), .dchan_clock_o(), .dchan_clock_oe_o(),
    .cs_n_i(cs_n_i), .ctrl_clock_i(ctrl_clock_i), .ctrl_data_in_i(ctrl_data_in_i),
    .ctrl_data_out_o(ctrl_data_out_o), .ctrl_data_out_oe_o(ctrl_data_out_oe_o),
    .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .line_status_i(line_status_i),
    .power_up_o(power_up_o), .cmd_one_o(cmd_one_o), .cmd_two_o(cmd_two_o),
    .tx_word_o(tx_word_o), .tx_word_valid_o(tx_word_valid_o), .tx_word_ready_i(tx_word_ready_i),
    .tx_overrun_o(tx_overrun_o), .rx_word_i(rx_word_i), .rx_word_valid_i(rx_word_valid_i),
    .rx_word_ready_o()
  );
  sctp_far_model far (.bclk_o(bclk), .tx_fs_o(tx_fs), .rx_fs_o(rx_fs), .bx_o(bx),
    .br_i(rx_serial_data_out_o), .br_oe_i(rx_serial_data_out_oe_o));

  // Core clock, 50 ns period
  initial core_clk_i = 1'b0;
  always #25 core_clk_i = ~core_clk_i;

  // Lost words seen at the port
  always @(posedge core_clk_i) begin
    if (tx_overrun_o === 1'b1) ovr++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Control transfer, MSB first; ctrl_clock high for 4 cycles and low for 8 keeps the synchroniser happy
  task automatic ctrl(input logic [15:0] f, input int nb, output logic [7:0] s);
    cs_n_i <= 1'b0;
    tick(8);
    for (int i = 0; i < nb; i++) begin
      ctrl_data_in_i <= f[15 - i];
      tick(4);
      if (i < 8) s[7 - i] = ctrl_data_out_o;
      ctrl_clock_i <= 1'b1;
      tick(4);
      ctrl_clock_i <= 1'b0;
      tick(4);
    end
    cs_n_i <= 1'b1;
    tick(8);
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 32'h0001122D;
    sel = 1'b1;
    {rstn_i, cs_n_i, ctrl_clock_i, ctrl_data_in_i} = 4'h4;
    {tx_word_ready_i, rx_word_valid_i, line_status_i, rx_word_i} = 28'h8000000;
    tick(4);
    rstn_i <= 1'b1;
    tick(3);
    chk({cmd_one_o, cmd_two_o, power_up_o, irq_oe_o}, 18'h00000);
    // Program while powered down; a 15-bit transfer must change nothing
    ctrl(16'h2008, 16, st);
    chk({cmd_two_o, power_up_o}, 9'h011);
    ctrl(16'h2009, 15, st);
    chk(cmd_two_o, 8'h08);
    // Status change latches the interrupt, a status read releases it
    seed = lfsr(seed);
    line_status_i <= seed[7:0] | 8'h80;
    tick(6);
    chk({irq_oe_o, irq_n_o}, 2'b10);
    ctrl(16'h0000, 8, st);
    chk(st, seed[7:0] | 8'h80);
    chk({irq_oe_o, ctrl_data_out_oe_o}, 2'b00);
    // Other interface mode: the control port must ignore a full write
    sel <= 1'b0;
    tick(4);
    ctrl(16'h2000, 16, st);
    chk(cmd_two_o, 8'h08);
    sel <= 1'b1;
    tick(4);
    // Master mode at every rate: eight generated periods measured in core cycles
    for (int r = 0; r < 5; r++) begin
      ctrl({8'h10, 5'h01, 3'(r)}, 16, st);
      tick(4);
      {n, cyc, prev} = {32'd0, 32'd0, bclk_o};
      while (n < 9 && cyc < 2000) begin
        @(negedge core_clk_i);
        cyc += (n > 0);
        n += (bclk_o && !prev);
        prev = bclk_o;
      end
      d = cyc - 160000 / khz[r];
      chk({bclk_oe_o, 1'(d >= -2 && d <= 2)}, 2'b11);
    end
    ctrl(16'h1000, 16, st);
    // Slave frames with the consumer stalled: the third word finds no room
    tick(20);
    tx_word_ready_i <= 1'b0;
    tick(4);
    ovr = 0;
    for (int f = 0; f < 3; f++) begin
      seed = lfsr(seed);
      rx_word_i <= seed[17:0];
      rx_word_valid_i <= (f < 2);
      tick(2);
      far.frame(seed[31:16], rxb, oe);
      chk(rxb, (f < 2) ? seed[17:2] : 16'hFFFF);
      chk(oe, 2'b10);
      if (txq.size() < 2) txq.push_back(seed[31:16]);
      else eovr++;
    end
    chk(ovr, eovr);
    // Drain in order until empty
    for (int i = 0; i < 2; i++) begin
      chk({tx_word_valid_o, tx_word_o[17:2]}, {1'b1, 16'(txq.pop_front())});
      tx_word_ready_i <= 1'b1;
      tick(1);
      tx_word_ready_i <= 1'b0;
      tick(2);
    end
    chk(tx_word_valid_o, 1'b0);
    conclude();
  end
endmodule
